// file: hw/rwf_defs.svh
// constants of the ring wake filter: offsets, bit positions, timing
// assumes inclusion by bare name from the package and the top design file
`ifndef RWF_DEFS_SVH
`define RWF_DEFS_SVH

// ----------------------------------------
// register offsets, configuration space
// ----------------------------------------
`define RWF_OFS_SOFT_EN2   8'hB1
`define RWF_OFS_SOFT_STS2  8'hB3
`define RWF_OFS_FILT_SEL   8'hC6

// ----------------------------------------
// register offsets, power-management block
// ----------------------------------------
`define RWF_OFS_PME_STS1   8'h0C
`define RWF_OFS_PME_EN1    8'h0E
`define RWF_OFS_SMI_EN1    8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define RWF_BIT_SOFT_RING  3
`define RWF_BIT_PME_RING   5
`define RWF_BIT_SMI_RING   0
`define RWF_BIT_FILT_EN    0
`define RWF_BIT_SRC_LO     1
`define RWF_BIT_SRC_HI     2
`define RWF_BIT_GPIO_SEL   3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RWF_RST_BYTE       8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define RWF_WINDOW_MS      200
`define RWF_SLOW_HZ        32768
`define RWF_EDGE_COUNT     3
`define RWF_SYS_HZ         100000000

`endif

// file: hw/rwf_edge_filter.sv
// sliding-window edge counter of the ring wake filter
// assumes tick is a one-cycle strobe per standby clock period
`timescale 1ns/1ns
`default_nettype none
module rwf_edge_filter
    import rwf_pkg::*;
#(
    parameter int WIN_TICKS = 6553,
    parameter int EDGES     = 3,
    parameter int CW        = $clog2(WIN_TICKS + 1)
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // control
    input  wire logic clear,
    input  wire logic tick,
    input  wire logic sample,
    // result
    output logic      active
);
    localparam logic [CW-1:0] WIN_C = CW'(WIN_TICKS);
    localparam logic [CW-1:0] ONE_C = CW'(1);

    // ----------------------------------------
    // ages of the most recent edges, in ticks
    // ----------------------------------------
    logic [CW-1:0] age_r   [EDGES];
    logic [CW-1:0] age_nxt [EDGES];
    logic          prev_r;
    logic          prev_nxt;
    logic          active_r;
    logic          active_nxt;
    logic          edge_seen;

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] a);
        sat_inc = (a >= WIN_C) ? WIN_C : a + ONE_C;
    endfunction : sat_inc

    always_comb begin
        edge_seen = tick && (sample != prev_r);
        prev_nxt  = tick ? sample : prev_r;
        for (int i = 0; i < EDGES; i++) begin
            age_nxt[i] = age_r[i];
        end
        if (clear) begin
            // expired ages: stale edges never count after a source change
            for (int i = 0; i < EDGES; i++) begin
                age_nxt[i] = WIN_C;
            end
            prev_nxt = sample;
        end else if (tick) begin
            for (int i = EDGES - 1; i > 0; i--) begin
                age_nxt[i] = edge_seen ? sat_inc(age_r[i-1]) : sat_inc(age_r[i]);
            end
            age_nxt[0] = edge_seen ? '0 : sat_inc(age_r[0]);
        end
        active_nxt = age_nxt[EDGES-1] < WIN_C;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < EDGES; i++) begin
                age_r[i] <= WIN_C;
            end
            prev_r   <= 1'b1;
            active_r <= 1'b0;
        end else begin
            for (int i = 0; i < EDGES; i++) begin
                age_r[i] <= age_nxt[i];
            end
            prev_r   <= prev_nxt;
            active_r <= active_nxt;
        end
    end

    assign active = active_r;
endmodule : rwf_edge_filter
`default_nettype wire

// file: hw/rwf_pkg.sv
// types shared by the ring wake filter files
// assumes rwf_defs.svh is on the include path
package rwf_pkg;
    `include "rwf_defs.svh"

    // ----------------------------------------
    // ring source selection
    // ----------------------------------------
    typedef enum logic [1:0] {
        RWF_SRC_RING    = 2'h0,
        RWF_SRC_SERIAL1 = 2'h1,
        RWF_SRC_SERIAL2 = 2'h2,
        RWF_SRC_NONE    = 2'h3
    } rwf_src_t;

    // ----------------------------------------
    // asynchronous pins: active low rings and the standby clock
    // ----------------------------------------
    typedef struct packed {
        logic gpio_pin_a_n;
        logic gpio_pin_b_n;
        logic serial1_ring_indicator_n;
        logic serial2_ring_indicator_n;
        logic standby_clk;
    } rwf_pins_t;

    // ----------------------------------------
    // register access request
    // ----------------------------------------
    typedef struct packed {
        logic       pm_space;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rwf_req_t;
endpackage : rwf_pkg

// file: hw/rwf_ring_wake_filter.sv
// ring wake filter: source select, filter, wake status and enables
// assumes one sys_clk domain; pins and standby clock are asynchronous
`timescale 1ns/1ns
`default_nettype none
// macros pulled in here as well, so compile order does not matter
`include "rwf_defs.svh"
module rwf_ring_wake_filter
    import rwf_pkg::*;
#(
    parameter int WIN_TICKS = (`RWF_WINDOW_MS * `RWF_SLOW_HZ) / 1000,
    parameter int EDGES     = `RWF_EDGE_COUNT
) (
    // clock and reset
    input  wire logic      sys_clk,
    input  wire logic      reset_n,
    // asynchronous pins
    input  wire rwf_pins_t pins,
    // register access
    input  wire rwf_req_t  req,
    output logic [7:0]     reg_rdata,
    output logic           reg_rvalid,
    // wake outputs
    output logic           ring_filter_out_n,
    output logic           power_on_request_n,
    output logic           smi_request,
    output logic           power_event_output_n
);
    localparam int NSYNC = 5;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    assign pin_raw = pins;

    // two flops per pin; nothing but the second stage reads the first
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_r[g] <= 1'b1;
                    sync2_r[g] <= 1'b1;
                end else begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    logic gpio_a_s;
    logic gpio_b_s;
    logic ser1_s;
    logic ser2_s;
    logic slow_s;
    assign {gpio_a_s, gpio_b_s, ser1_s, ser2_s, slow_s} = sync2_r;

    // ----------------------------------------
    // standby clock tick
    // ----------------------------------------
    logic slow_prev_r;
    logic slow_tick;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // high like the synchroniser, or a false tick follows reset
            slow_prev_r <= 1'b1;
        end else begin
            slow_prev_r <= slow_s;
        end
    end

    // one strobe per standby period paces all interval timing
    assign slow_tick = slow_s && !slow_prev_r;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] filt_sel_r;
    logic [7:0] filt_sel_nxt;
    logic [7:0] soft_en_r;
    logic [7:0] soft_en_nxt;
    logic [7:0] pme_en_r;
    logic [7:0] pme_en_nxt;
    logic [7:0] smi_en_r;
    logic [7:0] smi_en_nxt;
    logic       soft_flag_r;
    logic       soft_flag_nxt;
    logic       pme_flag_r;
    logic       pme_flag_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;
    logic       ring_evt;

    logic cfg_hit;
    logic pm_hit;
    assign cfg_hit = !req.pm_space;
    assign pm_hit  = req.pm_space;

    always_comb begin
        filt_sel_nxt  = filt_sel_r;
        soft_en_nxt   = soft_en_r;
        pme_en_nxt    = pme_en_r;
        smi_en_nxt    = smi_en_r;
        soft_flag_nxt = soft_flag_r;
        pme_flag_nxt  = pme_flag_r;
        rdata_nxt     = rdata_r;
        // every read is answered the next cycle, none refused
        rvalid_nxt    = req.rd;
        if (req.wr && cfg_hit && req.addr == `RWF_OFS_FILT_SEL) begin
            filt_sel_nxt = req.wdata;
        end
        if (req.wr && cfg_hit && req.addr == `RWF_OFS_SOFT_EN2) begin
            soft_en_nxt = req.wdata;
        end
        if (req.wr && pm_hit && req.addr == `RWF_OFS_PME_EN1) begin
            pme_en_nxt = req.wdata;
        end
        if (req.wr && pm_hit && req.addr == `RWF_OFS_SMI_EN1) begin
            smi_en_nxt = req.wdata;
        end
        // write one clears; a ring in the same cycle wins
        if (req.wr && pm_hit && req.addr == `RWF_OFS_PME_STS1
            && req.wdata[`RWF_BIT_PME_RING]) begin
            pme_flag_nxt = 1'b0;
        end
        // read clears; a ring in the same cycle wins
        if (req.rd && cfg_hit && req.addr == `RWF_OFS_SOFT_STS2) begin
            soft_flag_nxt = 1'b0;
        end
        if (ring_evt) begin
            soft_flag_nxt = 1'b1;
            pme_flag_nxt  = 1'b1;
        end
        if (req.rd) begin
            rdata_nxt = 8'h00;
            if (cfg_hit) begin
                unique case (req.addr)
                    `RWF_OFS_FILT_SEL:  rdata_nxt = filt_sel_r;
                    `RWF_OFS_SOFT_EN2:  rdata_nxt = soft_en_r;
                    `RWF_OFS_SOFT_STS2: rdata_nxt[`RWF_BIT_SOFT_RING] = soft_flag_r;
                    default:            rdata_nxt = 8'h00;
                endcase
            end else begin
                unique case (req.addr)
                    `RWF_OFS_PME_EN1:  rdata_nxt = pme_en_r;
                    `RWF_OFS_SMI_EN1:  rdata_nxt = smi_en_r;
                    // the same flag answers as SMI status
                    `RWF_OFS_PME_STS1: rdata_nxt[`RWF_BIT_PME_RING] = pme_flag_r;
                    default:           rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_sel_r  <= `RWF_RST_BYTE;
            soft_en_r   <= `RWF_RST_BYTE;
            pme_en_r    <= `RWF_RST_BYTE;
            smi_en_r    <= `RWF_RST_BYTE;
            soft_flag_r <= 1'b0;
            pme_flag_r  <= 1'b0;
            rdata_r     <= 8'h00;
            rvalid_r    <= 1'b0;
        end else begin
            filt_sel_r  <= filt_sel_nxt;
            soft_en_r   <= soft_en_nxt;
            pme_en_r    <= pme_en_nxt;
            smi_en_r    <= smi_en_nxt;
            soft_flag_r <= soft_flag_nxt;
            pme_flag_r  <= pme_flag_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
        end
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    logic     filt_en;
    rwf_src_t src;
    logic     ring_pin_s;
    logic     sel_level;
    logic     src_prev_r;
    logic     src_prev_nxt;
    logic     src_change;

    assign filt_en = filt_sel_r[`RWF_BIT_FILT_EN];
    assign src     = rwf_src_t'(filt_sel_r[`RWF_BIT_SRC_HI:`RWF_BIT_SRC_LO]);
    // alternate function: ring pin from either general-purpose pin
    assign ring_pin_s = filt_sel_r[`RWF_BIT_GPIO_SEL] ? gpio_b_s : gpio_a_s;

    always_comb begin
        unique case (src)
            RWF_SRC_RING:    sel_level = ring_pin_s;
            RWF_SRC_SERIAL1: sel_level = ser1_s;
            RWF_SRC_SERIAL2: sel_level = ser2_s;
            RWF_SRC_NONE:    sel_level = 1'b1;
        endcase
    end

    // any rewrite of the select register restarts the window
    always_comb begin
        src_prev_nxt = req.wr && cfg_hit && req.addr == `RWF_OFS_FILT_SEL;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_prev_r <= 1'b0;
        end else begin
            src_prev_r <= src_prev_nxt;
        end
    end
    assign src_change = src_prev_r || !filt_en;

    // ----------------------------------------
    // frequency filter
    // ----------------------------------------
    logic filt_active;

    rwf_edge_filter #(
        .WIN_TICKS (WIN_TICKS),
        .EDGES     (EDGES)
    ) u_edge_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (src_change),
        .tick    (slow_tick),
        .sample  (sel_level),
        .active  (filt_active)
    );

    // ----------------------------------------
    // wake path
    // ----------------------------------------
    logic filt_n_r;
    logic filt_n_nxt;
    logic pwr_n_r;
    logic pwr_n_nxt;
    logic smi_r;
    logic smi_nxt;
    logic pme_n_r;
    logic pme_n_nxt;

    always_comb begin
        // bypassed filter passes the raw ring pin, glitches and all
        filt_n_nxt = filt_en ? !filt_active : ring_pin_s;
        pwr_n_nxt  = !(soft_flag_nxt && soft_en_r[`RWF_BIT_SOFT_RING]);
        smi_nxt    = pme_flag_nxt && smi_en_r[`RWF_BIT_SMI_RING];
        pme_n_nxt  = !(pme_flag_nxt && pme_en_r[`RWF_BIT_PME_RING]);
    end

    // event on the falling edge of the filter output
    assign ring_evt = filt_n_r && !filt_n_nxt;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_n_r <= 1'b1;
            pwr_n_r  <= 1'b1;
            smi_r    <= 1'b0;
            pme_n_r  <= 1'b1;
        end else begin
            filt_n_r <= filt_n_nxt;
            pwr_n_r  <= pwr_n_nxt;
            smi_r    <= smi_nxt;
            pme_n_r  <= pme_n_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata            = rdata_r;
    assign reg_rvalid           = rvalid_r;
    assign ring_filter_out_n    = filt_n_r;
    assign power_on_request_n   = pwr_n_r;
    assign smi_request          = smi_r;
    assign power_event_output_n = pme_n_r;
endmodule : rwf_ring_wake_filter
`default_nettype wire

// file: verif/rwf_ring_src.sv
// far side model: modem ring lines, ring pin sources and standby clock
// assumes the bench calls toggle; lines idle high as if pulled up
`timescale 1ns/1ns
`default_nettype none
module rwf_ring_src
    import rwf_pkg::*;
#(
    parameter int HALF_NS = 100
) (
    // pins toward the filter
    output var rwf_pins_t pins
);
    // standby clock sped up so a window fits a short run
    initial begin
        pins = '1;
        forever #HALF_NS pins.standby_clk = ~pins.standby_clk;
    end

    // edges land 37 ns after a tick, never on a sampling edge
    task automatic toggle(input int idx, input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge pins.standby_clk);
            #37 pins[idx] = ~pins[idx];
        end
    endtask : toggle
endmodule : rwf_ring_src
`default_nettype wire

// file: verif/rwf_ring_wake_filter_chk.sv
// checker of the ring wake filter, sees the top ports only
// assumes rwf_pkg compiled first; bound in at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module rwf_ring_wake_filter_chk
    import rwf_pkg::*;
#(
    parameter int WIN_TICKS = 6553,
    parameter int EDGES     = 3
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // inputs
    input wire rwf_pins_t  pins,
    input wire rwf_req_t   req,
    // outputs
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       ring_filter_out_n,
    input wire logic       power_on_request_n,
    input wire logic       smi_request,
    input wire logic       power_event_output_n
);
    logic       mapped;
    logic [2:0] wr_hist_r;
    logic [2:0] wr_hist_nxt;
    logic [2:0] rd_hist_r;
    logic [2:0] rd_hist_nxt;

    always_comb begin
        if (req.pm_space) begin
            mapped = req.addr inside {8'h0C, 8'h0E, 8'h14};
        end else begin
            mapped = req.addr inside {8'hB1, 8'hB3, 8'hC6};
        end
        wr_hist_nxt = {wr_hist_r[1:0], req.wr};
        rd_hist_nxt = {rd_hist_r[1:0], req.rd};
    end

    // three cycles of history: an enable acts two edges later, a clear one edge later
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_hist_r <= '0;
            rd_hist_r <= '0;
        end else begin
            wr_hist_r <= wr_hist_nxt;
            rd_hist_r <= rd_hist_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_rvalid_pulse: assert property (req.rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(req.rd))
        else $error("answer without read");
    chk_unmapped_zero: assert property (req.rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved");
    chk_pwr_cause: assert property ($fell(power_on_request_n)
        |-> !ring_filter_out_n || (|wr_hist_r))
        else $error("power request without ring");
    chk_smi_cause: assert property ($rose(smi_request)
        |-> !ring_filter_out_n || (|wr_hist_r))
        else $error("smi without ring");
    chk_pme_cause: assert property ($fell(power_event_output_n)
        |-> !ring_filter_out_n || (|wr_hist_r))
        else $error("power event without ring");
    chk_pwr_release: assert property ($rose(power_on_request_n)
        |-> |(wr_hist_r | rd_hist_r))
        else $error("power request dropped alone");
    chk_smi_release: assert property ($fell(smi_request) |-> |wr_hist_r)
        else $error("smi dropped alone");
    chk_pme_release: assert property ($rose(power_event_output_n) |-> |wr_hist_r)
        else $error("power event dropped alone");

    cover property ($fell(ring_filter_out_n));
    cover property ($rose(smi_request));
    cover property (req.rd && !mapped);
endmodule : rwf_ring_wake_filter_chk

bind rwf_ring_wake_filter rwf_ring_wake_filter_chk #(
    .WIN_TICKS(WIN_TICKS),
    .EDGES    (EDGES)
) u_chk (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .pins                (pins),
    .req                 (req),
    .reg_rdata           (reg_rdata),
    .reg_rvalid          (reg_rvalid),
    .ring_filter_out_n   (ring_filter_out_n),
    .power_on_request_n  (power_on_request_n),
    .smi_request         (smi_request),
    .power_event_output_n(power_event_output_n)
);
`default_nettype wire

// file: verif/tb_rwf_ring_wake_filter.sv
// self-checking bench of the ring wake filter with a register model
// assumes package, design, ring source model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_rwf_ring_wake_filter;
    import rwf_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end

    localparam int WIN = 20; // short window keeps the run small
    logic       sys_clk;
    logic       reset_n;
    rwf_pins_t  pins;
    rwf_req_t   req;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       ring_filter_out_n;
    logic       power_on_request_n;
    logic       smi_request;
    logic       power_event_output_n;
    int         failures;
    int         n_tests;
    int         c_out, c_pwr, c_smi, c_pme; // active cycles per output
    int         m_soft, m_pme, m_smi;       // model of enable registers

    rwf_ring_wake_filter #(.WIN_TICKS(WIN), .EDGES(3)) u_dut (
        .sys_clk             (sys_clk),
        .reset_n             (reset_n),
        .pins                (pins),
        .req                 (req),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid),
        .ring_filter_out_n   (ring_filter_out_n),
        .power_on_request_n  (power_on_request_n),
        .smi_request         (smi_request),
        .power_event_output_n(power_event_output_n)
    );
    rwf_ring_src u_src (.pins(pins));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        c_out += !ring_filter_out_n;
        c_pwr += !power_on_request_n;
        c_smi += smi_request;
        c_pme += !power_event_output_n;
    end

    // hang guard, counted as a mismatch
    initial begin
        #500_000;
        $display("[FAIL] %0t run timed out", $time);
        failures++;
        close_out();
    end

    task close_out;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    task wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{pm_space: sp, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr

    task rd(input logic sp, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        req <= '{pm_space: sp, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, exp)
    endtask : rd

    task ring_case(input logic [7:0] sel, input int pin, input int gap, input bit hit);
        int o, p, s, e;
        m_soft = $urandom;
        m_pme  = $urandom;
        m_smi  = $urandom;
        wr(1'b0, 8'hB1, m_soft[7:0]);
        wr(1'b1, 8'h0E, m_pme[7:0]);
        wr(1'b1, 8'h14, m_smi[7:0]);
        wr(1'b0, 8'hC6, sel);
        rd(1'b0, 8'hC6, sel);
        rd(1'b0, 8'hB1, m_soft[7:0]);
        rd(1'b1, 8'h0E, m_pme[7:0]);
        rd(1'b1, 8'h14, m_smi[7:0]);
        o = c_out;
        p = c_pwr;
        s = c_smi;
        e = c_pme;
        u_src.toggle(pin, 4, gap);
        // 30 standby ticks, well past the window after the last edge
        repeat (WIN * 30) @(posedge sys_clk);
        #1;
        `CHK(c_out > o, hit)
        `CHK(c_pwr > p, hit && m_soft[3])
        `CHK(c_smi > s, hit && m_smi[0])
        `CHK(c_pme > e, hit && m_pme[5])
        `CHK(ring_filter_out_n, 1'b1)
        rd(1'b0, 8'hB3, {4'h0, hit, 3'h0});
        @(posedge sys_clk);
        #1;
        `CHK(power_on_request_n, 1'b1)
        rd(1'b0, 8'hB3, 8'h00);
        rd(1'b1, 8'h0C, {2'h0, hit, 5'h00});
        wr(1'b1, 8'h0C, 8'h20);
        rd(1'b1, 8'h0C, 8'h00);
        `CHK({smi_request, power_event_output_n}, 2'b01)
    endtask : ring_case

    initial begin
        void'($urandom(32'h50ce));
        reset_n  = 1'b0;
        req      = '0;
        failures = 0;
        n_tests  = 0;
        c_out    = 0;
        c_pwr    = 0;
        c_smi    = 0;
        c_pme    = 0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        `CHK({ring_filter_out_n, power_on_request_n, smi_request}, 3'b110)
        `CHK({power_event_output_n, reg_rvalid, reg_rdata}, 10'h200)
        // unmapped and status writes must leave the enable and status registers at zero
        wr(1'b0, 8'h0C, 8'hFF);
        wr(1'b0, 8'hB3, 8'hFF);
        wr(1'b1, 8'h0C, 8'hFF);
        rd(1'b0, 8'hB1, 8'h00);
        rd(1'b0, 8'hB3, 8'h00);
        rd(1'b1, 8'h0C, 8'h00);
        rd(1'b1, 8'h0E, 8'h00);
        rd(1'b1, 8'h14, 8'h00);
        rd(1'b0, 8'h55, 8'h00);
        rd(1'b1, 8'hB3, 8'h00);
        ring_case(8'h01, 4, 4, 1'b1);
        ring_case(8'h09, 3, 4, 1'b1);
        ring_case(8'h09, 4, 4, 1'b0);
        ring_case(8'h03, 2, 4, 1'b1);
        ring_case(8'h05, 1, 4, 1'b1);
        ring_case(8'h03, 1, 4, 1'b0);
        ring_case(8'h07, 2, 4, 1'b0);
        ring_case(8'h03, 2, 9, 1'b1);
        ring_case(8'h03, 2, 11, 1'b0);
        ring_case(8'h00, 4, 11, 1'b1);
        close_out();
    end
endmodule : tb_rwf_ring_wake_filter
`default_nettype wire
